// [logic/etq_top.v]
`timescale 1ns/100ps
`default_nettype none
`include "etq_defines.vh"

module etq_top #(
    parameter [9:0] ISO_HIGH_CYC = `ETQ_ISO_HIGH_CYC,
    parameter [9:0] ISO_LOW_CYC  = `ETQ_ISO_LOW_CYC,
    parameter [7:0] US_CYC       = `ETQ_US_CYC
) (
    input  wire       clk,
    input  wire       srst,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       trig_in,
    input  wire       enc_phase_a,
    input  wire       enc_phase_b,
    input  wire [1:0] strobe_level,
    output reg        acq_trigger,
    output reg        line_trigger,
    output reg  [1:0] strobe_out,
    output reg  [1:0] strobe_oe_n
);

// ----------------------------------------
// Address decode
// ----------------------------------------
function hit;
    input [3:0] a;
    input [3:0] target;
    begin
        hit = (a == target);
    end
endfunction

// ----------------------------------------
// Registers
// ----------------------------------------
reg  [7:0] ctrl;
reg  [7:0] debounce_setting;
reg  [7:0] trig_count;
reg        sw_fire;
reg        qual_fire;
reg  [1:0] state;
reg  [9:0] cyc_cnt;
reg  [7:0] pre_cnt;
reg  [7:0] us_cnt;
reg        trig_s;
reg        enc_a_s;
reg        enc_b_s;
reg        enc_a_q;

wire       trigger_polarity_select     = ctrl[`ETQ_CTRL_POL];
wire       encoder_line_trigger_enable = ctrl[`ETQ_CTRL_ENC];
wire [1:0] strobe_output_enable = ctrl[`ETQ_CTRL_STB_HI:`ETQ_CTRL_STB_LO];
wire       trig_active = trigger_polarity_select ? trig_s : ~trig_s;
wire [7:0] eff_deb;
wire [9:0] iso_target;

assign eff_deb = (debounce_setting == 8'h00) ? `ETQ_DEB_MIN
                                             : debounce_setting; // RQ9
assign iso_target = trigger_polarity_select ? ISO_HIGH_CYC
                                            : ISO_LOW_CYC; // RQ3 RQ4

always @(posedge clk) begin
    if (srst) begin
        ctrl             <= `ETQ_CTRL_RESET;
        debounce_setting <= `ETQ_DEB_RESET;
        sw_fire          <= 1'b0;
    end else begin
        sw_fire <= 1'b0;
        if (reg_wr && hit(reg_addr, `ETQ_ADDR_CTRL)) begin
            ctrl <= reg_wdata;
        end
        if (reg_wr && hit(reg_addr, `ETQ_ADDR_DEBOUNCE)) begin
            debounce_setting <= reg_wdata; // RQ2
        end
        if (reg_wr && hit(reg_addr, `ETQ_ADDR_SWTRIG)) begin
            sw_fire <= reg_wdata[`ETQ_SWTRIG_BIT]; // RQ6
        end
    end
end

// ----------------------------------------
// Read port
// ----------------------------------------
always @(posedge clk) begin
    if (srst) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        if (hit(reg_addr, `ETQ_ADDR_CTRL)) begin
            reg_rdata <= ctrl;
        end else if (hit(reg_addr, `ETQ_ADDR_DEBOUNCE)) begin
            reg_rdata <= debounce_setting;
        end else if (hit(reg_addr, `ETQ_ADDR_STATUS)) begin
            reg_rdata <= {2'h0, state, enc_b_s, enc_a_s,
                          trig_active, trig_s};
        end else if (hit(reg_addr, `ETQ_ADDR_COUNT)) begin
            reg_rdata <= trig_count;
        end else begin
            reg_rdata <= 8'h00;
        end
    end else begin
        reg_rdata <= 8'h00;
    end
end

// ----------------------------------------
// Trigger qualifier
// ----------------------------------------
always @(posedge clk) begin
    if (srst) begin
        trig_s    <= 1'b0;
        state     <= `ETQ_ST_IDLE;
        cyc_cnt   <= 10'h000;
        pre_cnt   <= 8'h00;
        us_cnt    <= 8'h00;
        qual_fire <= 1'b0;
    end else begin
        trig_s    <= trig_in;
        qual_fire <= 1'b0;
        case (state)
            `ETQ_ST_IDLE: begin
                cyc_cnt <= 10'h000;
                if (trig_active) begin
                    state <= `ETQ_ST_ISO;
                end
            end
            `ETQ_ST_ISO: begin
                if (!trig_active) begin
                    state <= `ETQ_ST_IDLE; // RQ1
                end else if (cyc_cnt == iso_target - 10'h001) begin
                    state   <= `ETQ_ST_DEB; // RQ3 RQ4
                    pre_cnt <= 8'h00;
                    us_cnt  <= 8'h00;
                end else begin
                    cyc_cnt <= cyc_cnt + 10'h001;
                end
            end
            `ETQ_ST_DEB: begin
                if (!trig_active) begin
                    state <= `ETQ_ST_IDLE; // RQ10
                end else if (pre_cnt == US_CYC - 8'h01) begin
                    pre_cnt <= 8'h00;
                    if (us_cnt + 8'h01 == eff_deb) begin
                        state     <= `ETQ_ST_HELD; // RQ1
                        qual_fire <= 1'b1;
                    end else begin
                        us_cnt <= us_cnt + 8'h01; // RQ10
                    end
                end else begin
                    pre_cnt <= pre_cnt + 8'h01;
                end
            end
            `ETQ_ST_HELD: begin
                if (!trig_active) begin
                    state <= `ETQ_ST_IDLE;
                end
            end
            default: begin
                state <= `ETQ_ST_IDLE;
            end
        endcase
    end
end

// ----------------------------------------
// Acquisition trigger
// ----------------------------------------
always @(posedge clk) begin
    if (srst) begin
        acq_trigger <= 1'b0;
        trig_count  <= 8'h00;
    end else begin
        acq_trigger <= qual_fire | sw_fire; // RQ6
        if (qual_fire | sw_fire) begin
            trig_count <= trig_count + 8'h01;
        end
    end
end

// ----------------------------------------
// Shaft encoder
// ----------------------------------------
always @(posedge clk) begin
    if (srst) begin
        enc_a_s      <= 1'b0;
        enc_b_s      <= 1'b0;
        enc_a_q      <= 1'b0;
        line_trigger <= 1'b0;
    end else begin
        enc_a_s      <= enc_phase_a;
        enc_b_s      <= enc_phase_b;
        enc_a_q      <= enc_a_s;
        line_trigger <= encoder_line_trigger_enable
                        & enc_a_s & ~enc_a_q; // RQ8
    end
end

// ----------------------------------------
// Strobe outputs
// ----------------------------------------
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_strobe
        always @(posedge clk) begin
            if (srst) begin
                strobe_out[gi]  <= 1'b0;
                strobe_oe_n[gi] <= 1'b1; // RQ7
            end else begin
                strobe_oe_n[gi] <= ~strobe_output_enable[gi]; // RQ7
                strobe_out[gi]  <= strobe_output_enable[gi]
                                   & strobe_level[gi];
            end
        end
    end
endgenerate

endmodule
`default_nettype wire

// [pkg/etq_defines.vh]
//
// Function
// RQ1 - Trigger valid only if held beyond isolator delay plus debounce time
// RQ2 - Debounce programmable in 1 us steps from 1 to 255 us
// RQ3 - Active high: valid trigger at edge plus 0.5 us plus debounce
// RQ4 - Active low: valid trigger at edge plus 4.2 us plus debounce
// RQ5 - Outside source should prefer active-high trigger drive
// RQ6 - Software trigger acts exactly like a validated external trigger
// RQ7 - Each strobe output high impedance until software enables it
// RQ8 - Quadrature encoder phases A and B serve as line trigger source; code uses only phase A rising edges, phase B only shows in the status register
// RQ9 - Debounce setting zero uses the one microsecond minimum
// RQ10 - Debounce counts 1 us ticks while asserted, restarts on deassert
//
`ifndef ETQ_DEFINES_VH
`define ETQ_DEFINES_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define ETQ_CLK_PERIOD_NS 5
`define ETQ_NS_PER_US     1000
`define ETQ_ISO_HIGH_NS   500
`define ETQ_ISO_LOW_NS    4200
`define ETQ_DEB_MIN       8'h01
// Cycle counts at the 5 ns board clock
`define ETQ_ISO_HIGH_CYC  10'h064
`define ETQ_ISO_LOW_CYC   10'h348
`define ETQ_US_CYC        8'hc8
`define ETQ_DEB_RESET     8'h01

// ----------------------------------------
// Register map
// ----------------------------------------
`define ETQ_ADDR_CTRL     4'h0
`define ETQ_ADDR_DEBOUNCE 4'h1
`define ETQ_ADDR_SWTRIG   4'h2
`define ETQ_ADDR_STATUS   4'h3
`define ETQ_ADDR_COUNT    4'h4

// ----------------------------------------
// Control fields
// ----------------------------------------
`define ETQ_CTRL_POL      0
`define ETQ_CTRL_ENC      1
`define ETQ_CTRL_STB_LO   2
`define ETQ_CTRL_STB_HI   3
`define ETQ_CTRL_RESET    8'h01
`define ETQ_SWTRIG_BIT    0

// ----------------------------------------
// Qualifier states
// ----------------------------------------
`define ETQ_ST_IDLE       2'h0
`define ETQ_ST_ISO        2'h1
`define ETQ_ST_DEB        2'h2
`define ETQ_ST_HELD       2'h3

`endif

// [tb/etq_top_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module etq_chk #(
    parameter [9:0] ISO_HIGH_CYC = 10'h4,
    parameter [9:0] ISO_LOW_CYC  = 10'h8,
    parameter [7:0] US_CYC       = 8'h4
) (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       trig_in,
    input wire logic       enc_phase_a,
    input wire logic       acq_trigger,
    input wire logic       line_trigger,
    input wire logic [1:0] strobe_out,
    input wire logic [1:0] strobe_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic        pol;
    logic        enc;
    logic [15:0] run;
    logic [7:0]  deb;
    wire logic act = pol ? trig_in : ~trig_in;
    wire logic sw = reg_wr && reg_addr == 4'h2 && reg_wdata[0];
    wire logic cw = reg_wr && reg_addr == 4'h0;
    wire logic dw = reg_wr && reg_addr == 4'h1;
    wire logic [7:0] eff = (deb == 8'h0) ? 8'h1 : deb;
    wire logic [15:0] need = (pol ? ISO_HIGH_CYC : ISO_LOW_CYC)
                             + US_CYC * eff;
    // Polarity, encoder enable, active run length
    always_ff @(posedge clk) begin
        if (srst) begin
            pol <= 1'b1;
            enc <= 1'b0;
            run <= 16'h0;
            deb <= 8'h1;
        end else begin
            if (dw) begin
                deb <= reg_wdata;
            end
            if (cw) begin
                pol <= reg_wdata[0];
                enc <= reg_wdata[1];
            end
            run <= act ? run + 16'h1 : 16'h0;
        end
    end
    property p_sw; sw |-> ##2 acq_trigger; endproperty
    a_sw: assert property (p_sw) else $error("sw");
    property p_held; acq_trigger && !$past(sw, 2)
        |-> $past(run, 2) > need; endproperty
    a_held: assert property (p_held) else $error("held");
    property p_one; acq_trigger |=> !acq_trigger; endproperty
    a_one: assert property (p_one) else $error("one");
    property p_oe; cw |-> ##2 strobe_oe_n == ~$past(reg_wdata[3:2], 2);
    endproperty
    a_oe: assert property (p_oe) else $error("oe");
    property p_z0; strobe_oe_n[0] |-> !strobe_out[0]; endproperty
    a_z0: assert property (p_z0) else $error("z0");
    property p_z1; strobe_oe_n[1] |-> !strobe_out[1]; endproperty
    a_z1: assert property (p_z1) else $error("z1");
    property p_ln; $rose(enc_phase_a) && enc |-> ##2 line_trigger; endproperty
    a_ln: assert property (p_ln) else $error("ln");
    property p_lnen; line_trigger |-> $past(enc); endproperty
    a_lnen: assert property (p_lnen) else $error("lnen");
endmodule
`default_nettype wire

// [tb/etq_far.sv]
`timescale 1ns/100ps
`default_nettype none
module etq_far (
    input  wire logic clk,
    output logic      trig_in,
    output logic      enc_phase_a,
    output logic      enc_phase_b
);
    initial begin
        trig_in = 1'b0;
        enc_phase_a = 1'b0;
        enc_phase_b = 1'b0;
    end
    task automatic idle(input logic v);
        trig_in <= v;
    endtask
    // Trigger pulse of n cycles, then idle level
    task automatic pulse(input logic lvl, input int n);
        trig_in <= lvl;
        repeat (n) @(posedge clk);
        trig_in <= ~lvl;
        @(posedge clk);
    endtask
    // One quadrature cycle, B lagging A
    task automatic step();
        enc_phase_a <= 1'b1;
        repeat (3) @(posedge clk);
        enc_phase_b <= 1'b1;
        repeat (3) @(posedge clk);
        enc_phase_a <= 1'b0;
        repeat (3) @(posedge clk);
        enc_phase_b <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [tb/etq_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module etq_top_tb;
    localparam int ISH = 4, ISL = 8, US = 4;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0, p;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, d;
    logic [1:0] strobe_level = 0, strobe_out, strobe_oe_n;
    logic trig_in, enc_phase_a, enc_phase_b, acq_trigger, line_trigger;
    logic [31:0] cyc = 0, rq[$], tq[$];
    int err_count = 0, checked = 0, lines = 0, seed = 90, i, n;
    etq_top #(.ISO_HIGH_CYC(10'd4), .ISO_LOW_CYC(10'd8), .US_CYC(8'd4))
        u_etq_top (
            .clk          (clk),
            .srst         (srst),
            .reg_addr     (reg_addr),
            .reg_wdata    (reg_wdata),
            .reg_wr       (reg_wr),
            .reg_rd       (reg_rd),
            .reg_rdata    (reg_rdata),
            .trig_in      (trig_in),
            .enc_phase_a  (enc_phase_a),
            .enc_phase_b  (enc_phase_b),
            .strobe_level (strobe_level),
            .acq_trigger  (acq_trigger),
            .line_trigger (line_trigger),
            .strobe_out   (strobe_out),
            .strobe_oe_n  (strobe_oe_n)
        );
    etq_far u_etq_far (
        .clk         (clk),
        .trig_in     (trig_in),
        .enc_phase_a (enc_phase_a),
        .enc_phase_b (enc_phase_b)
    );
    initial forever #2.5 clk = ~clk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1;
        @(posedge clk);
        reg_wr <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1;
        rq.push_back({24'h0, e});
        @(posedge clk);
        reg_rd <= 0;
        @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rd_d <= reg_rd;
        if (rd_d) chk(reg_rdata, rq.pop_front());
        if (acq_trigger) chk(cyc, tq.pop_front());
        if (line_trigger) lines++;
        if (cyc > 5000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 0;
        strobe_level <= 2'($random(seed));
        @(posedge clk);
        chk(strobe_oe_n, 2'b11);
        rd(0, 8'h01);
        rd(1, 8'h01);
        rd(4'hf, 8'h00);
        tq.push_back(cyc + 3);
        wr(2, 8'h01);
        rd(2, 8'h00);
        $display("registers and soft trigger done");
        for (i = 0; i < 4; i++) begin
            p = ~i[0];
            d = (i == 0) ? 8'h0 : 8'($random(seed) & 3);
            u_etq_far.idle(~p);
            wr(0, {7'h0, p});
            wr(1, d);
            rd(1, d);
            n = (p ? ISH : ISL) + ((d == 0) ? 1 : d) * US;
            u_etq_far.pulse(p, n - 2);
            repeat (4) @(posedge clk);
            tq.push_back(cyc + 4 + n);
            u_etq_far.pulse(p, n + 8);
            repeat (4) @(posedge clk);
        end
        $display("external trigger done");
        rd(4, 8'h05);
        u_etq_far.idle(1'b0);
        wr(0, 8'h0f);
        @(posedge clk);
        chk(strobe_oe_n, 2'b00);
        chk(strobe_out, strobe_level);
        repeat (3) u_etq_far.step();
        chk(lines, 3);
        wr(0, 8'h01);
        @(posedge clk);
        chk(strobe_oe_n, 2'b11);
        chk(strobe_out, 2'b00);
        u_etq_far.step();
        chk(lines, 3);
        $display("strobe and encoder done");
        chk(tq.size(), 0);
        chk(rq.size(), 0);
        wrap_up();
    end
endmodule
bind etq_top etq_chk #(.ISO_HIGH_CYC(ISO_HIGH_CYC), .ISO_LOW_CYC(ISO_LOW_CYC),
    .US_CYC(US_CYC)) u_etq_chk (
    .clk          (clk),
    .srst         (srst),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .trig_in      (trig_in),
    .enc_phase_a  (enc_phase_a),
    .acq_trigger  (acq_trigger),
    .line_trigger (line_trigger),
    .strobe_out   (strobe_out),
    .strobe_oe_n  (strobe_oe_n)
);
`default_nettype wire
